// >>> capture_channel.sv
// One edge-triggered position capture channel.
// Assumes a synchronised trigger level and same-clock position words.
`timescale 1ns/10ps
module capture_channel (
  input wire logic core_clk,
  input wire logic reset,
  capture_if.chan ch
);
  import capture_pkg::*;

  logic trigPrev_r;
  logic hit;

  // ==========================================================================
  // Edge qualification.
  // Previous level always tracks, so enabling never sees a stale edge.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      trigPrev_r <= 1'b0;
    end else begin
      trigPrev_r <= ch.trig;
    end
  end

  // Mode picks which transitions count; off blocks everything.
  always_comb begin
    unique case (ch.mode)
      CAP_RISE: hit = ch.trig & ~trigPrev_r;
      CAP_FALL: hit = ~ch.trig & trigPrev_r;
      CAP_BOTH: hit = ch.trig ^ trigPrev_r;
      CAP_OFF: hit = 1'b0;
    endcase
  end

  // Mode register keeps the low two bits of the written word.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ch.mode <= CAP_OFF;
    end else if (ch.modeWr) begin
      ch.mode <= cap_mode_t'(ch.wrData[1:0]);
    end
  end

  // Starting a mode restarts the count; a start outranks a same-cycle edge.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ch.count <= REG_RESET;
    end else if (ch.modeWr && ch.wrData[1:0] != 2'b00) begin
      ch.count <= REG_RESET;
    end else if (hit) begin
      ch.count <= ch.count + 32'h0000_0001;
    end else if (ch.cntWr) begin
      ch.count <= ch.wrData;
    end
  end

  // A capture outranks a software write in the same cycle.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ch.pos <= REG_RESET;
      ch.raw <= REG_RESET;
    end else begin
      if (hit) begin
        ch.pos <= ch.userPos;
      end else if (ch.posWr) begin
        ch.pos <= ch.wrData;
      end
      if (hit) begin
        ch.raw <= ch.rawPos;
      end else if (ch.rawWr) begin
        ch.raw <= ch.wrData;
      end
    end
  end

  // Event pulse for the interrupt logic, one cycle per capture.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ch.event_ <= 1'b0;
    end else begin
      ch.event_ <= hit;
    end
  end
endmodule // capture_channel

// >>> capture_if.sv
// Bundle between the register file and one capture channel.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface capture_if;
  import capture_pkg::*;
  logic modeWr;
  logic cntWr;
  logic posWr;
  logic rawWr;
  logic [31:0] wrData;
  logic trig;
  logic [31:0] userPos;
  logic [31:0] rawPos;
  cap_mode_t mode;
  logic [31:0] count;
  logic [31:0] pos;
  logic [31:0] raw;
  logic event_;

  modport chan (
    input modeWr, cntWr, posWr, rawWr, wrData, trig, userPos, rawPos,
    output mode, count, pos, raw, event_
  );
  modport ctrl (
    output modeWr, cntWr, posWr, rawWr, wrData, trig, userPos, rawPos,
    input mode, count, pos, raw, event_
  );
endinterface // capture_if

// >>> capture_pkg.sv
// Constants shared by the input capture and routing block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package capture_pkg;

  // ==========================================================================
  // Bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] CAP1_MODE_OFS = 8'h00;
  localparam logic [7:0] CAP1_COUNT_OFS = 8'h04;
  localparam logic [7:0] CAP1_POS_OFS = 8'h08;
  localparam logic [7:0] CAP1_RAW_OFS = 8'h0C;
  localparam logic [7:0] HOME_MODE_OFS = 8'h10;
  localparam logic [7:0] HOME_COUNT_OFS = 8'h14;
  localparam logic [7:0] HOME_POS_OFS = 8'h18;
  localparam logic [7:0] HOME_RAW_OFS = 8'h1C;
  localparam logic [7:0] ROUTE_EN_OFS = 8'h20;
  localparam logic [7:0] HOME_SEL_OFS = 8'h24;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h28;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h2C;
  localparam logic [7:0] STATE_LO_OFS = 8'h30;
  localparam logic [7:0] STATE_HI_OFS = 8'h34;
  localparam logic [7:0] SEL_BASE_OFS = 8'h40;

  // ==========================================================================
  // Reset values and field positions.
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [3:0] HOME_SEL_RESET = 4'h2;
  localparam int IRQ_CAP1_BIT = 0;
  localparam int IRQ_HOME_BIT = 1;
  localparam int IRQ_W = 2;

  // ==========================================================================
  // Capture edge modes.
  typedef enum logic [1:0] {
    CAP_OFF = 2'b00,
    CAP_RISE = 2'b01,
    CAP_FALL = 2'b10,
    CAP_BOTH = 2'b11
  } cap_mode_t;

  // ==========================================================================
  // Source selector codes.
  localparam logic [7:0] SRC_ZERO = 8'h00;
  localparam logic [7:0] SRC_PHYS_FIRST = 8'h01;
  localparam logic [7:0] SRC_PHYS_LAST = 8'h10;
  localparam logic [7:0] SRC_ENC_FIRST = 8'h44;
  localparam logic [7:0] SRC_ENC_LAST = 8'h46;
  localparam logic [7:0] SRC_ONE = 8'h80;
  localparam logic [7:0] SRC_INV_FIRST = 8'h81;
  localparam logic [7:0] SRC_INV_LAST = 8'h90;
  localparam logic [7:0] SRC_INV_ENC_FIRST = 8'hC4;
  localparam logic [7:0] SRC_INV_ENC_LAST = 8'hC6;

endpackage

// >>> encoder_switch_model.sv
// Model of the switches and encoder that sit in front of the capture block.
// Assumes the bench calls drive from its main sequence, clocked by core_clk.
`timescale 1ns/10ps
module encoder_switch_model (
  input wire logic core_clk,
  output logic [15:0] physIn,
  output logic encA,
  output logic encB,
  output logic encIndex,
  output logic [31:0] userPosition,
  output logic [31:0] rawPosition
);
  // ==========================================================================
  // Levels start low so the synchronisers see a quiet line out of reset.
  initial begin
    physIn = 16'h0000;
    {encA, encB, encIndex} = 3'b000;
    userPosition = 32'h0;
    rawPosition = 32'h0;
  end

  // Each change lands just after a rising edge, so it never races a sample.
  task automatic drive(input logic [15:0] p, input logic [2:0] e,
                       input logic [31:0] u, input logic [31:0] r);
    @(posedge core_clk);
    physIn <= p;
    {encA, encB, encIndex} <= e;
    userPosition <= u;
    rawPosition <= r;
  endtask
endmodule // encoder_switch_model

// >>> input_capture_and_routing.sv
// Input capture and routing block with an AXI4-Lite register slave.
// Assumes physical and encoder pins are asynchronous and positions are on core_clk.
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps

// How it works
// - Mode 1 captures rising, 2 falling, 3 both edges.
// - Mode 0 disables the channel: no capture, no count change.
// - A 32-bit counter adds one per captured edge since start.
// - Writing mode 1, 2 or 3 clears that channel's counter.
// - Each capture latches the user-unit position.
// - Each capture also latches the raw sensor position.
// - Second channel triggers on the home-switch input, otherwise identical.
// - 36 eight-bit selectors; selector n drives state word bit n-1.
// - Codes 81 to 90 route inverted physical inputs 1 to 16.
// - Codes 44-46 route encoder A, B, index; C4-C6 inverted.
// - First channel triggers on digital input 1.
// - Routing enable zero switches routing off, one switches it on.
module input_capture_and_routing #(
  parameter int NUM_INPUTS = 16,
  parameter int NUM_SELECTORS = 36
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [NUM_INPUTS-1:0] physIn,
  input wire logic encA,
  input wire logic encB,
  input wire logic encIndex,
  input wire logic [31:0] userPosition,
  input wire logic [31:0] rawPosition,
  input wire logic [capture_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [capture_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [capture_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [capture_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [NUM_SELECTORS-1:0] digitalInputStateWord,
  output logic irq
);
  import capture_pkg::*;

  // ==========================================================================
  // Elaboration checks.
  // Selector codes reach only sixteen physical inputs, and the state word
  // read-back spans two 32-bit registers.
  if (NUM_INPUTS < 1 || NUM_INPUTS > 16) begin : g_bad_inputs
    $error("NUM_INPUTS must be 1 to 16.");
  end
  if (NUM_SELECTORS < 1 || NUM_SELECTORS > 36) begin : g_bad_selectors
    $error("NUM_SELECTORS must be 1 to 36.");
  end
  localparam int SYNC_W = NUM_INPUTS + 3;

  // ==========================================================================
  // Pin synchronisers.
  logic [SYNC_W-1:0] syncMeta_r;
  logic [SYNC_W-1:0] syncOut_r;
  logic [NUM_INPUTS-1:0] physSync;
  logic [2:0] encSync;
  // Two flops per pin; only the second flop is read by logic.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      syncMeta_r <= '0;
      syncOut_r <= '0;
    end else begin
      syncMeta_r <= {encIndex, encB, encA, physIn};
      syncOut_r <= syncMeta_r;
    end
  end
  assign physSync = syncOut_r[NUM_INPUTS-1:0];
  assign encSync = syncOut_r[SYNC_W-1:NUM_INPUTS];

  // ==========================================================================
  // Control registers.
  logic routeEn_r;
  logic [3:0] homeSel_r;
  logic [IRQ_W-1:0] irqStatus_r;
  logic [IRQ_W-1:0] irqMask_r;
  logic [7:0] sel_r [NUM_SELECTORS];
  logic [NUM_SELECTORS-1:0] stateWord_r;

  // ==========================================================================
  // Capture channels.
  capture_if cap1 ();
  capture_if home ();
  logic homeTrig;
  // Home switch is whichever physical input the select register names.
  always_comb begin
    homeTrig = 1'b0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (homeSel_r == 4'(i)) begin
        homeTrig = physSync[i];
      end
    end
  end

  assign cap1.trig = physSync[0];
  assign home.trig = homeTrig;
  assign cap1.userPos = userPosition;
  assign cap1.rawPos = rawPosition;
  assign home.userPos = userPosition;
  assign home.rawPos = rawPosition;
  capture_channel u_cap1 (
    .core_clk(core_clk),
    .reset(reset),
    .ch(cap1.chan)
  );
  capture_channel u_home (
    .core_clk(core_clk),
    .reset(reset),
    .ch(home.chan)
  );

  // ==========================================================================
  // Write channel.
  logic awHeld_r;
  logic wHeld_r;
  logic [ADDR_W-1:0] wAddr_r;
  logic [DATA_W-1:0] wData_r;
  logic [3:0] wStrb_r;
  logic doWrite;
  logic wrHit;
  logic fullWord;
  assign doWrite = awHeld_r & wHeld_r & ~bvalid;
  // Partial-word writes are refused rather than merged.
  assign fullWord = (wStrb_r == 4'hF);
  // Address and data are taken independently and held until the write.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      awHeld_r <= 1'b0;
      wAddr_r <= '0;
    end else if (awvalid && awready) begin
      awHeld_r <= 1'b1;
      wAddr_r <= awaddr;
    end else if (doWrite) begin
      awHeld_r <= 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wHeld_r <= 1'b0;
      wData_r <= '0;
      wStrb_r <= 4'h0;
    end else if (wvalid && wready) begin
      wHeld_r <= 1'b1;
      wData_r <= wdata;
      wStrb_r <= wstrb;
    end else if (doWrite) begin
      wHeld_r <= 1'b0;
    end
  end

  // Ready is offered only while nothing of that kind is held.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      awready <= 1'b0;
      wready <= 1'b0;
    end else begin
      awready <= ~awHeld_r & ~(awvalid & awready) & ~bvalid & ~doWrite;
      wready <= ~wHeld_r & ~(wvalid & wready) & ~bvalid & ~doWrite;
    end
  end
  // Address decode of the held write.
  always_comb begin
    wrHit = 1'b0;
    unique case (wAddr_r)
      CAP1_MODE_OFS, CAP1_COUNT_OFS, CAP1_POS_OFS, CAP1_RAW_OFS,
      HOME_MODE_OFS, HOME_COUNT_OFS, HOME_POS_OFS, HOME_RAW_OFS,
      ROUTE_EN_OFS, HOME_SEL_OFS, IRQ_STATUS_OFS, IRQ_MASK_OFS,
      STATE_LO_OFS, STATE_HI_OFS: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
    for (int i = 0; i < NUM_SELECTORS; i++) begin
      if (wAddr_r == SEL_BASE_OFS + 8'(4 * i)) begin
        wrHit = 1'b1;
      end
    end
  end

  // Write response follows both halves one cycle after they are held.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp <= (wrHit && fullWord) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end
  // One-cycle strobes into the channels.
  logic wrEn;
  assign wrEn = doWrite & fullWord;
  assign cap1.wrData = wData_r;
  assign home.wrData = wData_r;
  assign cap1.modeWr = wrEn & (wAddr_r == CAP1_MODE_OFS);
  assign cap1.cntWr = wrEn & (wAddr_r == CAP1_COUNT_OFS);
  assign cap1.posWr = wrEn & (wAddr_r == CAP1_POS_OFS);
  assign cap1.rawWr = wrEn & (wAddr_r == CAP1_RAW_OFS);
  assign home.modeWr = wrEn & (wAddr_r == HOME_MODE_OFS);
  assign home.cntWr = wrEn & (wAddr_r == HOME_COUNT_OFS);
  assign home.posWr = wrEn & (wAddr_r == HOME_POS_OFS);
  assign home.rawWr = wrEn & (wAddr_r == HOME_RAW_OFS);

  // Routing enable and home-input select.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      routeEn_r <= 1'b0;
      homeSel_r <= HOME_SEL_RESET;
    end else if (wrEn) begin
      if (wAddr_r == ROUTE_EN_OFS) begin
        routeEn_r <= wData_r[0];
      end
      if (wAddr_r == HOME_SEL_OFS) begin
        homeSel_r <= wData_r[3:0];
      end
    end
  end

  // Source selectors, one word each.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_SELECTORS; i++) begin
        sel_r[i] <= SEL_RESET;
      end
    end else if (wrEn) begin
      for (int i = 0; i < NUM_SELECTORS; i++) begin
        if (wAddr_r == SEL_BASE_OFS + 8'(4 * i)) begin
          sel_r[i] <= wData_r[7:0];
        end
      end
    end
  end

  // ==========================================================================
  // Interrupts.
  // A capture arriving with a write-one-to-clear still leaves its bit set.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irqStatus_r <= '0;
      irqMask_r <= '0;
      irq <= 1'b0;
    end else begin
      if (wrEn && wAddr_r == IRQ_STATUS_OFS) begin
        irqStatus_r <= (irqStatus_r & ~wData_r[IRQ_W-1:0]) | {home.event_, cap1.event_};
      end else begin
        irqStatus_r <= irqStatus_r | {home.event_, cap1.event_};
      end
      if (wrEn && wAddr_r == IRQ_MASK_OFS) begin
        irqMask_r <= wData_r[IRQ_W-1:0];
      end
      irq <= |(irqStatus_r & irqMask_r);
    end
  end

  // ==========================================================================
  // Routing stage.
  function automatic logic routeBit(
    input logic [7:0] code,
    input logic [NUM_INPUTS-1:0] phys,
    input logic [2:0] enc
  );
    logic [7:0] idx;
    routeBit = 1'b0;
    idx = 8'h00;
    if (code == SRC_ZERO) begin
      routeBit = 1'b0;
    end else if (code == SRC_ONE) begin
      routeBit = 1'b1;
    end else if (code >= SRC_PHYS_FIRST && code <= SRC_PHYS_LAST) begin
      idx = code - SRC_PHYS_FIRST;
      routeBit = (idx < 8'(NUM_INPUTS)) ? phys[idx[3:0]] : 1'b0;
    end else if (code >= SRC_INV_FIRST && code <= SRC_INV_LAST) begin
      idx = code - SRC_INV_FIRST;
      routeBit = (idx < 8'(NUM_INPUTS)) ? ~phys[idx[3:0]] : 1'b0;
    end else if (code >= SRC_ENC_FIRST && code <= SRC_ENC_LAST) begin
      idx = code - SRC_ENC_FIRST;
      routeBit = enc[idx[1:0]];
    end else if (code >= SRC_INV_ENC_FIRST && code <= SRC_INV_ENC_LAST) begin
      idx = code - SRC_INV_ENC_FIRST;
      routeBit = ~enc[idx[1:0]];
    end
  endfunction

  // With routing off, the word mirrors the physical inputs one to one so
  // software still sees the raw switches.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stateWord_r <= '0;
    end else begin
      for (int i = 0; i < NUM_SELECTORS; i++) begin
        if (routeEn_r) begin
          stateWord_r[i] <= routeBit(sel_r[i], physSync, encSync);
        end else begin
          stateWord_r[i] <= (i < NUM_INPUTS) ? physSync[i] : 1'b0;
        end
      end
    end
  end
  assign digitalInputStateWord = stateWord_r;

  // ==========================================================================
  // Read channel.
  logic [DATA_W-1:0] rdMux;
  logic rdHit;
  logic [63:0] stateWide;
  assign stateWide = 64'(stateWord_r);
  always_comb begin
    rdHit = 1'b1;
    rdMux = '0;
    unique case (araddr)
      CAP1_MODE_OFS: rdMux = 32'(cap1.mode);
      CAP1_COUNT_OFS: rdMux = cap1.count;
      CAP1_POS_OFS: rdMux = cap1.pos;
      CAP1_RAW_OFS: rdMux = cap1.raw;
      HOME_MODE_OFS: rdMux = 32'(home.mode);
      HOME_COUNT_OFS: rdMux = home.count;
      HOME_POS_OFS: rdMux = home.pos;
      HOME_RAW_OFS: rdMux = home.raw;
      ROUTE_EN_OFS: rdMux = 32'(routeEn_r);
      HOME_SEL_OFS: rdMux = 32'(homeSel_r);
      IRQ_STATUS_OFS: rdMux = 32'(irqStatus_r);
      IRQ_MASK_OFS: rdMux = 32'(irqMask_r);
      STATE_LO_OFS: rdMux = stateWide[31:0];
      STATE_HI_OFS: rdMux = stateWide[63:32];
      default: rdHit = 1'b0;
    endcase
    for (int i = 0; i < NUM_SELECTORS; i++) begin
      if (araddr == SEL_BASE_OFS + 8'(4 * i)) begin
        rdHit = 1'b1;
        rdMux = 32'(sel_r[i]);
      end
    end
  end

  // The address is taken and answered on the next edge.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      arready <= ~rvalid & ~(arvalid & arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rdMux;
        rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule // input_capture_and_routing

// >>> input_capture_and_routing_monitor.sv
// Concurrent checks on the register bus and the routed state word.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module input_capture_and_routing_monitor
  import capture_pkg::*;
#(
  parameter int NUM_INPUTS = 16,
  parameter int NUM_SELECTORS = 36
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [NUM_INPUTS-1:0] physIn,
  input wire logic encA,
  input wire logic encB,
  input wire logic encIndex,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [capture_pkg::DATA_W-1:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [NUM_SELECTORS-1:0] digitalInputStateWord
);
  // ==========================================================================
  // All checks share the one clock and its synchronous reset.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  sequence writeTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  // Five quiet cycles cover two sync flops plus the routing register.
  sequence quietIn;
    $stable(physIn) && $stable({encA, encB, encIndex}) && !awvalid && !bvalid;
  endsequence

  a_write_answer: assert property (writeTaken |=> ##1 bvalid)
    else $error("write response not on time");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data not on time");
  a_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_read_block: assert property (rvalid |-> !arready)
    else $error("read accepted while answering");
  a_write_block: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while answering");
  a_read_end: assert property (rvalid && rready |=> !rvalid ##[0:1] arready)
    else $error("read channel not reopened");
  a_write_end: assert property (bvalid && bready |=> !bvalid ##[0:1] (awready && wready))
    else $error("write channel not reopened");
  a_state_quiet: assert property (quietIn [*5] |-> $stable(digitalInputStateWord))
    else $error("state word moved with quiet inputs");
endmodule // input_capture_and_routing_monitor

// >>> input_capture_and_routing_tb.sv
// Self-checking bench for the capture and routing block over AXI4-Lite.
// Assumes the switch and encoder model drives every pin of the far side.
`timescale 1ns/10ps
module input_capture_and_routing_tb;
  import capture_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] physIn;
  logic encA, encB, encIndex;
  logic [31:0] userPosition, rawPosition, wdata = 32'h0, rdata, pe;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [35:0] digitalInputStateWord;
  int n_mismatch = 0;
  int checked = 0;
  int i, m;

  always #50 core_clk = ~core_clk;

  input_capture_and_routing dut (.core_clk, .reset, .physIn, .encA, .encB, .encIndex,
    .userPosition, .rawPosition, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .digitalInputStateWord, .irq);
  encoder_switch_model sw (.core_clk, .physIn, .encA, .encB, .encIndex, .userPosition,
    .rawPosition);

  // ==========================================================================
  // Verdict, comparison and bus tasks.
  task automatic summarize;
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  // A hung handshake counts as a mismatch and ends the run at once.
  task automatic hang;
    n_mismatch++;
    $display("wrong value at %0t ns: no bus answer", $time);
    summarize();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic done;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
        done = 1'b1;
      end
    end
    if (!done) hang();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        check(rdata, ed);
        check({30'h0, rresp}, {30'h0, er});
        done = 1'b1;
      end
    end
    if (!done) hang();
  endtask

  // Selector one feeds bit zero; three cycles cover the routing register.
  task automatic sel(input logic [7:0] code, input logic exp);
    wr(SEL_BASE_OFS, {24'h0, code}, 4'hF, RESP_OKAY);
    repeat (3) @(posedge core_clk);
    check({31'h0, digitalInputStateWord[0]}, {31'h0, exp});
  endtask

  // Eight cycles per level give the synchronisers and capture time to settle.
  task automatic pulse(input int b, input logic [31:0] pr, input logic [31:0] pf);
    sw.drive(16'(16'h0001 << b), 3'b000, pr, ~pr);
    repeat (8) @(posedge core_clk);
    sw.drive(16'h0000, 3'b000, pf, ~pf);
    repeat (8) @(posedge core_clk);
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    for (i = 0; i < 8; i++) rd(8'(4 * i), REG_RESET, RESP_OKAY);
    rd(HOME_SEL_OFS, 32'h2, RESP_OKAY);
    rd(SEL_BASE_OFS, 32'h0, RESP_OKAY);
    rd(8'h3C, 32'h0, RESP_SLVERR);
    wr(CAP1_POS_OFS, 32'hA5A5_0000, 4'h3, RESP_SLVERR);
    wr(CAP1_POS_OFS, 32'hA5A5_0000, 4'hF, RESP_OKAY);
    rd(CAP1_POS_OFS, 32'hA5A5_0000, RESP_OKAY);
    // Each mode sees one rise then one fall, with a new position at each.
    for (m = 1; m < 4; m++) begin
      wr(CAP1_MODE_OFS, 32'(m), 4'hF, RESP_OKAY);
      rd(CAP1_COUNT_OFS, 32'h0, RESP_OKAY);
      pulse(0, 32'h1000 + m, 32'h2000 + m);
      pe = (m == 1) ? 32'h1000 + m : 32'h2000 + m;
      rd(CAP1_COUNT_OFS, (m == 3) ? 32'h2 : 32'h1, RESP_OKAY);
      rd(CAP1_POS_OFS, pe, RESP_OKAY);
      rd(CAP1_RAW_OFS, ~pe, RESP_OKAY);
    end
    wr(CAP1_MODE_OFS, 32'h0, 4'hF, RESP_OKAY);
    pulse(0, 32'h3000, 32'h3001);
    rd(CAP1_COUNT_OFS, 32'h2, RESP_OKAY);
    rd(CAP1_POS_OFS, 32'h2003, RESP_OKAY);
    wr(HOME_MODE_OFS, 32'h3, 4'hF, RESP_OKAY);
    wr(CAP1_MODE_OFS, 32'h3, 4'hF, RESP_OKAY);
    pulse(2, 32'h4000, 32'h4001);
    rd(HOME_COUNT_OFS, 32'h2, RESP_OKAY);
    rd(HOME_POS_OFS, 32'h4001, RESP_OKAY);
    rd(HOME_RAW_OFS, ~32'h4001, RESP_OKAY);
    wr(HOME_SEL_OFS, 32'h4, 4'hF, RESP_OKAY);
    rd(HOME_SEL_OFS, 32'h4, RESP_OKAY);
    pulse(4, 32'h5000, 32'h5001);
    rd(HOME_COUNT_OFS, 32'h4, RESP_OKAY);
    rd(HOME_POS_OFS, 32'h5001, RESP_OKAY);
    rd(CAP1_COUNT_OFS, 32'h0, RESP_OKAY);
    // Both channels have fired; only the masked-in one may raise the line.
    rd(IRQ_STATUS_OFS, 32'h3, RESP_OKAY);
    check({31'h0, irq}, 32'h0);
    wr(IRQ_MASK_OFS, 32'h1, 4'hF, RESP_OKAY);
    repeat (3) @(posedge core_clk);
    check({31'h0, irq}, 32'h1);
    wr(IRQ_STATUS_OFS, 32'h1, 4'hF, RESP_OKAY);
    rd(IRQ_STATUS_OFS, 32'h2, RESP_OKAY);
    check({31'h0, irq}, 32'h0);
    // Routing: one-hot inputs expose a wrong index in either polarity.
    wr(ROUTE_EN_OFS, 32'h1, 4'hF, RESP_OKAY);
    wr(SEL_BASE_OFS + 8'h8C, 32'h80, 4'hF, RESP_OKAY);
    for (i = 0; i < 16; i++) begin
      sw.drive(16'(16'h0001 << i), 3'b000, 32'h0, 32'h0);
      sel(8'(i + 1), 1'b1);
      sel(8'(8'h81 + i), 1'b0);
    end
    sw.drive(16'hFFFF, 3'b101, 32'h0, 32'h0);
    for (i = 0; i < 3; i++) begin
      sel(8'(8'h44 + i), i != 1);
      sel(8'(8'hC4 + i), i == 1);
    end
    sel(8'h00, 1'b0);
    sel(8'h80, 1'b1);
    sel(8'h20, 1'b0);
    sel(8'hFF, 1'b0);
    check({28'h0, digitalInputStateWord[35:32]}, 32'h8);
    rd(STATE_HI_OFS, 32'h8, RESP_OKAY);
    wr(ROUTE_EN_OFS, 32'h0, 4'hF, RESP_OKAY);
    repeat (3) @(posedge core_clk);
    check({31'h0, digitalInputStateWord[35]}, 32'h0);
    summarize();
  end
endmodule // input_capture_and_routing_tb

bind input_capture_and_routing input_capture_and_routing_monitor #(
  .NUM_INPUTS(NUM_INPUTS), .NUM_SELECTORS(NUM_SELECTORS)) mon (.core_clk, .reset,
  .physIn, .encA, .encB, .encIndex, .awvalid, .awready, .wvalid, .wready, .bresp,
  .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .digitalInputStateWord);
